// file: hdl/spi_frame_pkg.sv
// Purpose: Shared constants and types of the SPI frame port
// Assumes: SPI mode 0, link clock stands still outside frames
// Notes:   Frame is 29 bits, read/write bit first
package spi_frame_pkg;

  localparam int FRAME_BITS = 29;
  localparam int CNT_W      = 5;
  localparam int NUM_PORTS  = 2;
  localparam int PORT_BIT   = 10;
  localparam int DEV_BIT    = 8;

  localparam logic [3:0] PAGE_P0_DEV0 = 4'h0;
  localparam logic [3:0] PAGE_P0_DEV1 = 4'h1;
  localparam logic [3:0] PAGE_P1_DEV0 = 4'h4;
  localparam logic [3:0] PAGE_P1_DEV1 = 4'h5;
  localparam logic [3:0] PAGE_LOCAL   = 4'h8;

  localparam logic [FRAME_BITS-1:0] DUMMY_FRAME = 29'h1FFFFFFF;

  typedef enum logic [0:0] {
    OP_WRITE = 1'b0,
    OP_READ  = 1'b1
  } op_t;

  typedef enum {
    TGT_NONE,
    TGT_LOCAL,
    TGT_PORT
  } target_t;

  // Frame layout, bit 28 down to bit 0
  typedef struct packed {
    logic        rw;
    logic [11:0] addr;
    logic        busy;
    logic        spare14;
    logic        nack;
    logic        reject;
    logic [3:0]  spare;
    logic [7:0]  data;
  } frame_t;

  typedef struct packed {
    logic       valid;
    logic       rw;
    logic       port;
    logic       dev;
    logic [7:0] offset;
    logic [7:0] wdata;
  } ds_req_t;

  typedef struct packed {
    logic       done;
    logic       busy;
    logic       nack;
    logic [7:0] rdata;
  } ds_rsp_t;

endpackage

// file: hdl/bit_sync.sv
// Purpose: Two-flop level synchroniser
// Assumes: Input is a slow level from another domain
// Notes:   First stage feeds only the second
module bit_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic din,
  output logic      dout
);

  logic meta_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_q <= RESET_VAL;
      dout   <= RESET_VAL;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end

endmodule // bit_sync

// file: hdl/local_reg_mem.sv
// Purpose: Small register store with registered read data
// Assumes: One write port, one read port, same clock
// Notes:   Contents are cleared by reset
module local_reg_mem #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  input  wire logic          clock,
  input  wire logic          rst,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata_q
);

  logic [DW-1:0] mem_q [2**AW];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 2**AW; i++) begin
        mem_q[i] <= '0;
      end
    end else if (we) begin
      mem_q[waddr] <= wdata;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= mem_q[raddr];
    end
  end

endmodule // local_reg_mem

// file: hdl/spi_host_frame_port.sv
// Purpose: Host-side SPI frame port with local registers and downstream requests
// Assumes: Mode 0 link clock, downstream engine on the system clock
// Notes:   Serial output enable and first bit are combinational from select
module spi_host_frame_port
  import spi_frame_pkg::*;
#(
  parameter int REG_AW = 8
) (
  input  wire logic    clock,
  input  wire logic    rst,
  input  wire logic    link_sck,
  input  wire logic    select_pin,
  input  wire logic    serial_in_pin,
  output logic         serial_out_pin,
  output logic         serial_out_oe,
  output ds_req_t      ds_req_q,
  input  wire ds_rsp_t ds_rsp [NUM_PORTS]
);

  // ***************************************************************
  // Link clock domain
  // ***************************************************************
  logic                  link_idle;
  logic [CNT_W-1:0]      rx_cnt_q;
  logic [CNT_W-1:0]      tx_cnt_q;
  logic [FRAME_BITS-1:0] shift_q;
  logic                  len_ok_q;
  logic                  out_q;
  frame_t                tx_word_q;

  // Counters end with the frame's own select edge
  assign link_idle = rst | select_pin;

  always_ff @(posedge link_sck or posedge link_idle) begin
    if (link_idle) begin
      rx_cnt_q <= '0;
    end else if (rx_cnt_q != '1) begin
      rx_cnt_q <= rx_cnt_q + CNT_W'(1);
    end
  end

  // First edge loads the response, later edges shift the chain through
  always_ff @(posedge link_sck or posedge rst) begin
    if (rst) begin
      shift_q <= '0;
    end else if (!select_pin) begin
      if (rx_cnt_q == '0) begin
        shift_q <= {tx_word_q[FRAME_BITS-2:0], serial_in_pin};
      end else begin
        shift_q <= {shift_q[FRAME_BITS-2:0], serial_in_pin};
      end
    end
  end

  // Set only when the edge just taken was the 29th of the frame
  always_ff @(posedge link_sck or posedge rst) begin
    if (rst) begin
      len_ok_q <= 1'b0;
    end else if (!select_pin) begin
      len_ok_q <= (rx_cnt_q == CNT_W'(FRAME_BITS - 1));
    end
  end

  always_ff @(negedge link_sck or posedge link_idle) begin
    if (link_idle) begin
      tx_cnt_q <= '0;
    end else if (tx_cnt_q != '1) begin
      tx_cnt_q <= tx_cnt_q + CNT_W'(1);
    end
  end

  always_ff @(negedge link_sck or posedge rst) begin
    if (rst) begin
      out_q <= 1'b0;
    end else begin
      out_q <= shift_q[FRAME_BITS-1];
    end
  end

  // Enable follows select without any clock
  assign serial_out_oe  = ~select_pin;
  assign serial_out_pin = (tx_cnt_q == '0) ? tx_word_q.rw : out_q;

  // ***************************************************************
  // Frame end detection on the system clock
  // ***************************************************************
  logic sel_s;
  logic sel_d_q;
  logic frame_end;

  bit_sync #(
    .RESET_VAL (1'b1)
  ) u_sel_sync (
    .clock (clock),
    .rst   (rst),
    .din   (select_pin),
    .dout  (sel_s)
  );

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sel_d_q <= 1'b1;
    end else begin
      sel_d_q <= sel_s;
    end
  end

  assign frame_end = sel_s & ~sel_d_q;

  // ***************************************************************
  // Command decode
  // ***************************************************************
  frame_t  cmd;
  target_t cmd_tgt;
  logic    cmd_valid;
  logic    cmd_port;
  logic    port_busy;
  logic    cmd_exec;
  logic    cmd_accept;
  logic    port_busy_v [NUM_PORTS];

  // Shift register is static here: link clock stopped with select high
  assign cmd       = frame_t'(shift_q);

  always_comb begin
    case (cmd.addr[11:8])
      PAGE_P0_DEV0,
      PAGE_P0_DEV1,
      PAGE_P1_DEV0,
      PAGE_P1_DEV1: cmd_tgt = TGT_PORT;
      PAGE_LOCAL:   cmd_tgt = TGT_LOCAL;
      default:      cmd_tgt = TGT_NONE;
    endcase
  end

  assign cmd_port   = cmd.addr[PORT_BIT];
  assign cmd_valid  = frame_end & len_ok_q & (shift_q != DUMMY_FRAME);
  assign port_busy  = port_busy_v[cmd_port];
  assign cmd_exec   = cmd_valid & (cmd_tgt != TGT_NONE);
  assign cmd_accept = cmd_exec & ((cmd_tgt != TGT_PORT) | ~port_busy);

  // ***************************************************************
  // Port busy
  // ***************************************************************
  // Busy also covers the cycle in which a request has just left
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_busy
    assign port_busy_v[p] = ds_rsp[p].busy
                          | (ds_req_q.valid & (ds_req_q.port == 1'(p)));
  end

  // ***************************************************************
  // Executed command and refusal
  // ***************************************************************
  frame_t  last_q;
  target_t last_tgt_q;
  logic    reject_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      last_q <= '0;
    end else if (cmd_exec) begin
      last_q <= cmd;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      last_tgt_q <= TGT_NONE;
    end else if (cmd_exec) begin
      last_tgt_q <= cmd_tgt;
    end
  end

  // Refusal stays in every response until the next executed command updates it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reject_q <= 1'b0;
    end else if (cmd_exec) begin
      reject_q <= ~cmd_accept;
    end
  end

  // ***************************************************************
  // Downstream requests
  // ***************************************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ds_req_q <= '0;
    end else begin
      ds_req_q.valid <= 1'b0;
      if (cmd_accept && cmd_tgt == TGT_PORT) begin
        ds_req_q.valid  <= 1'b1;
        ds_req_q.rw     <= cmd.rw;
        ds_req_q.port   <= cmd_port;
        ds_req_q.dev    <= cmd.addr[DEV_BIT];
        ds_req_q.offset <= cmd.addr[7:0];
        ds_req_q.wdata  <= cmd.data;
      end
    end
  end

  // Per-port read data and not-acknowledge
  logic [7:0] port_rdata_q [NUM_PORTS];
  logic       port_nack_q  [NUM_PORTS];

  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        port_rdata_q[p] <= '0;
      end else if (ds_rsp[p].done) begin
        port_rdata_q[p] <= ds_rsp[p].rdata;
      end
    end

    // Done wins over the clear of a fresh request
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        port_nack_q[p] <= 1'b0;
      end else if (ds_rsp[p].done) begin
        port_nack_q[p] <= ds_rsp[p].nack;
      end else if (ds_req_q.valid && ds_req_q.port == 1'(p)) begin
        port_nack_q[p] <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // Local registers
  // ***************************************************************
  logic [7:0] local_rdata;
  logic       reg_we;

  // Only a whole, valid frame may touch the store
  assign reg_we = cmd_exec & (cmd_tgt == TGT_LOCAL) & (cmd.rw == OP_WRITE);

  local_reg_mem #(
    .AW (REG_AW),
    .DW (8)
  ) u_regs (
    .clock   (clock),
    .rst     (rst),
    .we      (reg_we),
    .waddr   (cmd.addr[REG_AW-1:0]),
    .wdata   (cmd.data),
    .raddr   (last_q.addr[REG_AW-1:0]),
    .rdata_q (local_rdata)
  );

  // ***************************************************************
  // Response word for the next frame
  // ***************************************************************
  frame_t resp;
  logic   last_port;

  assign last_port = last_q.addr[PORT_BIT];

  always_comb begin
    resp         = last_q;
    resp.busy    = 1'b0;
    resp.spare14 = 1'b0;
    resp.spare   = '0;
    resp.reject  = reject_q;
    resp.nack    = 1'b0;
    if (last_tgt_q == TGT_PORT) begin
      resp.nack = port_nack_q[last_port];
      if (last_q.rw == OP_READ) begin
        resp.busy = port_busy_v[last_port];
        resp.data = port_rdata_q[last_port];
      end
    end else if (last_tgt_q == TGT_LOCAL && last_q.rw == OP_READ) begin
      resp.data = local_rdata;
    end
  end

  // ***************************************************************
  // Response hand-over to the link domain
  // ***************************************************************
  // Link reads this word only at a frame's first edge and as the
  // first output bit; held while synced select is low
  logic tx_load;

  assign tx_load = sel_s & sel_d_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_word_q <= '0;
    end else if (tx_load) begin
      tx_word_q <= resp;
    end
  end

endmodule // spi_host_frame_port

// file: verification/spi_host_frame_port_props.sv
// Purpose: Port-level properties of the SPI frame port
// Assumes: Bound to the top module
// Notes:   Only the in-frame enable check runs on the link clock
module spi_host_frame_port_props
  import spi_frame_pkg::*;
(
  input wire logic    clock,
  input wire logic    rst,
  input wire logic    link_sck,
  input wire logic    select_pin,
  input wire logic    serial_out_oe,
  input wire ds_req_t ds_req_q,
  input wire ds_rsp_t ds_rsp [NUM_PORTS]
);
  oe_idle_a: assert property (@(posedge clock) disable iff (rst) serial_out_oe == !select_pin)
    else $error("enable does not mirror select");
  oe_frame_a: assert property (@(posedge link_sck) disable iff (rst) !select_pin |-> serial_out_oe)
    else $error("output off inside frame");
  req_after_rise_a: assert property (@(posedge clock) disable iff (rst)
    ds_req_q.valid |-> $past(select_pin) && $past(select_pin, 2)) else $error("request before select rise");
  req_spacing_a: assert property (@(posedge clock) disable iff (rst)
    ds_req_q.valid |=> !ds_req_q.valid [*8]) else $error("requests too close");
  req_hold_a: assert property (@(posedge clock) disable iff (rst)
    !ds_req_q.valid |-> $stable(ds_req_q[18:0])) else $error("request fields moved");
  busy0_refuse_a: assert property (@(posedge clock) disable iff (rst)
    ds_req_q.valid && !ds_req_q.port |-> !$past(ds_rsp[0].busy)) else $error("request to busy port 0");
  busy1_refuse_a: assert property (@(posedge clock) disable iff (rst)
    ds_req_q.valid && ds_req_q.port |-> !$past(ds_rsp[1].busy)) else $error("request to busy port 1");
  req_in_frame_a: assert property (@(posedge clock) disable iff (rst)
    select_pin ##1 !select_pin [*6] |-> !ds_req_q.valid) else $error("request inside frame");
  rd_c: cover property (@(posedge clock) ds_req_q.valid && ds_req_q.rw);
  wr_c: cover property (@(posedge clock) ds_req_q.valid && !ds_req_q.rw);
  sel_c: cover property (@(posedge clock) $fell(select_pin));
endmodule // spi_host_frame_port_props

bind spi_host_frame_port spi_host_frame_port_props props (.clock(clock), .rst(rst), .link_sck(link_sck),
  .select_pin(select_pin), .serial_out_oe(serial_out_oe), .ds_req_q(ds_req_q), .ds_rsp(ds_rsp));

// file: verification/spi_host_model.sv
// Purpose: Host SPI controller model
// Assumes: Mode 0, clock idle low, 32 ns period
// Notes:   Idle input shows inverse of last bit
module spi_host_model (
  output logic      link_sck,
  output logic      select_pin,
  output logic      serial_in_pin,
  input  wire logic serial_out_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    link_sck      = 1'b0;
    select_pin    = 1'b1;
    serial_in_pin = 1'b0;
  end
  task automatic xfer(input logic [28:0] tx, output logic [28:0] rx);
    select_pin = 1'b0;
    for (int i = 28; i >= 0; i--) begin
      serial_in_pin = tx[i];
      #16 link_sck = 1'b1;
      rx[i] = serial_out_pin;
      #16 link_sck = 1'b0;
    end
    #16 select_pin = 1'b1;
    serial_in_pin = ~serial_in_pin;
  endtask
endmodule // spi_host_model

// file: verification/spi_host_frame_port_test.sv
// Purpose: Self-checking bench of the SPI frame port
// Assumes: Bench plays the downstream engine
// Notes:   Each response is checked in the next frame
module spi_host_frame_port_test;
  import spi_frame_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LAT = 300;
  localparam logic [3:0] PG [4] = '{4'h0, 4'h1, 4'h4, 4'h5};
  logic        clock = 1'b0;
  logic        rst   = 1'b1;
  logic        sck, sel, mosi, miso, oe;
  ds_req_t     req;
  ds_rsp_t     rsp [NUM_PORTS];
  int          n_fail, total_checks, cyc, kind, kport;
  int          cnt [2];
  logic [7:0]  mem [256], rd [2], off [4];
  logic        nk [2];
  logic [31:0] rng = 32'h45;
  logic [28:0] exp, msk, rx;
  ds_req_t     q [$];

  spi_host_frame_port dut (.clock(clock), .rst(rst), .link_sck(sck), .select_pin(sel), .serial_in_pin(mosi),
    .serial_out_pin(miso), .serial_out_oe(oe), .ds_req_q(req), .ds_rsp(rsp));
  spi_host_model host (.link_sck(sck), .select_pin(sel), .serial_in_pin(mosi), .serial_out_pin(miso));

  always #10 clock = ~clock;

  function automatic logic [7:0] rb();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng[7:0];
  endfunction

  task automatic check(string what, logic [28:0] e, logic [28:0] s, logic [28:0] m);
    total_checks++;
    if ((s & m) !== (e & m)) begin
      n_fail++;
      $display("BAD %s exp %h got %h", what, e & m, s & m);
    end
  endtask

  task automatic summarize();
    if (n_fail == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Downstream engine
  always @(negedge clock) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      summarize();
    end
    if (!rst && req.valid === 1'b1) begin
      check("req", q.size() ? 29'(q.pop_front()) : '1, 29'(req), 29'h7FFFF);
      cnt[req.port] = LAT;
      rd[req.port] = rb();
      nk[req.port] = rb() > 8'h7F;
    end
    for (int p = 0; p < 2; p++) begin
      rsp[p] <= '{done: cnt[p] == 1, busy: cnt[p] > 1, nack: nk[p], rdata: rd[p]};
      if (cnt[p] > 0) cnt[p]--;
    end
  end

  // One frame: check last response, then model this command
  task automatic frame(logic [28:0] tx, int gap);
    logic [28:0] m;
    logic        p;
    m = msk;
    p = tx[26];
    if (kind == 1) begin
      exp[15] = cnt[kport] > 0;
      exp[13] = nk[kport];
      exp[7:0] = rd[kport];
      if (exp[15]) m = {13'h1FFF, 16'h8000};
    end
    check("oe_idle", 29'h0, 29'(oe), 29'h1);
    host.xfer(tx, rx);
    check("miso", exp, rx, m);
    if (tx !== DUMMY_FRAME && tx[27:24] inside {4'h0, 4'h1, 4'h4, 4'h5, 4'h8}) begin
      kind = 0;
      msk = '1;
      exp = {tx[28:16], 8'h00, tx[7:0]};
      if (tx[27:24] == 4'h8) begin
        if (tx[28]) exp[7:0] = mem[tx[23:16]];
        else mem[tx[23:16]] = tx[7:0];
      end else if (cnt[p] > 0) begin
        exp = {tx[28:16], 16'h1000};
        msk = {13'h1FFF, 16'h1000};
      end else begin
        q.push_back({1'b1, tx[28], p, tx[24], tx[23:16], tx[7:0]});
        kind = int'(tx[28]);
        kport = int'(p);
        msk[13] = tx[28];
      end
    end
    #(gap);
  endtask

  initial begin
    rsp[0] = '0;
    rsp[1] = '0;
    rd = '{8'h00, 8'h00};
    nk = '{1'b0, 1'b0};
    foreach (mem[i]) mem[i] = 8'h00;
    exp = '0;
    msk = '1;
    repeat (20) @(posedge clock);
    @(negedge clock) rst = 1'b0;
    repeat (4) @(negedge clock);
    foreach (off[i]) begin
      off[i] = rb();
      frame({5'h08, off[i], 8'h00, rb()}, 200);
    end
    foreach (off[i]) begin
      frame({5'h18, off[i], 16'h0000}, 1000);
      frame(DUMMY_FRAME, 1000);
    end
    frame(DUMMY_FRAME, 200);
    frame({5'h02, 8'h11, 8'h00, 8'hAA}, 200);
    foreach (PG[i]) begin
      frame({1'b1, PG[i], rb(), 16'h0000}, 200);
      frame(DUMMY_FRAME, LAT * 20 + 500);
    end
    frame({5'h14, 8'h20, 16'h0000}, 200);
    frame({5'h14, 8'h21, 16'h0000}, 200);
    frame({5'h01, 8'h30, 8'h00, 8'h5A}, 200);
    frame({5'h05, 8'h31, 8'h00, 8'hA5}, 200);
    frame(DUMMY_FRAME, LAT * 20 + 500);
    frame({5'h04, 8'h40, 8'h00, 8'h66}, 200);
    frame(DUMMY_FRAME, 200);
    summarize();
  end
endmodule // spi_host_frame_port_test
